// file: conv_sequencer.sv
// conversion scheduler: periodic and one-shot conversions, busy flag, abort on standby
`timescale 1ns/1ps
module conv_sequencer #(
	parameter longint PERIOD_CYCLES = temp_smbus_pkg::FAST_PERIOD_CYCLES,
	parameter longint CONV_CYCLES = temp_smbus_pkg::CONV_CYCLES
) (
	input wire logic sys_clk_i, // system clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic [2:0] rate_sel_i, // conversion rate code, 7 is fastest
	input wire logic hw_standby_i, // synchronised pin standby
	input wire logic sw_standby_i, // software standby bit
	input wire logic one_shot_i, // one-cycle one-shot request
	output logic busy_o, // conversion in progress
	output logic done_o // one-cycle pulse at normal completion
);
	logic [47:0] period_cnt_q;
	logic [47:0] conv_cnt_q;
	logic busy_q;
	logic done_q;
	logic sw_standby_q;

	// period doubles for every code step below the fastest rate
	wire [2:0] rate_shift = temp_smbus_pkg::RATE_FASTEST[2:0] - rate_sel_i;
	wire [47:0] period_len = 48'(PERIOD_CYCLES) << rate_shift;
	wire period_hit = (period_cnt_q >= period_len - 48'h0001);
	wire conv_end = busy_q && (conv_cnt_q >= 48'(CONV_CYCLES) - 48'h0001);
	wire standby = hw_standby_i || sw_standby_i;
	// a standby that arrives mid-conversion kills it; a one-shot under soft standby survives
	wire abort = busy_q && (hw_standby_i || (sw_standby_i && !sw_standby_q));
	wire shot_start = one_shot_i && !hw_standby_i && !busy_q;
	wire auto_start = !standby && !busy_q && period_hit;
	wire start = shot_start || auto_start;

	// free-running period timer, held in standby
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			period_cnt_q <= 48'h0000_0000_0000;
		end else if (standby || period_hit) begin
			period_cnt_q <= 48'h0000_0000_0000;
		end else begin
			period_cnt_q <= period_cnt_q + 48'h0000_0000_0001;
		end
	end

	// conversion timer and busy flag; an aborted conversion never pulses done
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			conv_cnt_q <= 48'h0000_0000_0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			sw_standby_q <= 1'b0;
		end else begin
			sw_standby_q <= sw_standby_i;
			done_q <= 1'b0;
			if (abort) begin
				busy_q <= 1'b0;
			end else if (conv_end) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end else if (start) begin
				busy_q <= 1'b1;
				conv_cnt_q <= 48'h0000_0000_0000;
			end else if (busy_q) begin
				conv_cnt_q <= conv_cnt_q + 48'h0000_0000_0001;
			end
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
endmodule

// file: smbus_host_model.sv
// behavioural smbus host master for the temperature block
`timescale 1ns/1ps
module smbus_host_model #(
	parameter int Q = 3
) (
	input wire logic sys_clk_i, // system clock
	input wire logic sda_i, // data wire level
	output logic scl_o, // clock line
	output logic sda_low_o // high pulls data low
);
	// bus idles with clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// quarter-bit pacing
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	// one clock pulse, reply sampled while clock high
	task automatic bt(input logic b, output logic r);
		sda_low_o <= !b;
		w(Q);
		scl_o <= 1'b1;
		w(Q);
		r = sda_i;
		w(Q);
		scl_o <= 1'b0;
		w(Q);
	endtask
	// start or repeated start
	task automatic start();
		sda_low_o <= 1'b0;
		w(Q);
		scl_o <= 1'b1;
		w(Q);
		sda_low_o <= 1'b1;
		w(Q);
		scl_o <= 1'b0;
		w(Q);
	endtask
	task automatic stop();
		sda_low_o <= 1'b1;
		w(Q);
		scl_o <= 1'b1;
		w(Q);
		sda_low_o <= 1'b0;
		w(Q);
	endtask
	// byte out msb first, ack returned
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bt(d[i], r);
		bt(1'b1, r);
		ack = !r;
	endtask
	// byte in msb first, closed by nack
	task automatic rx(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
		bt(1'b1, r);
	endtask
	// k: 0 write byte, 1 send byte, 2 read byte, 3 receive byte; sole master
	task automatic xfer(input logic [6:0] a, input int k, input logic [7:0] c,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		logic x;
		q = 8'h00;
		start();
		tx({a, k == 3}, ok);
		if (k != 3) begin
			tx(c, x);
			ok = ok & x;
		end
		if (k == 0) begin
			tx(d, x);
			ok = ok & x;
		end
		if (k == 2) begin
			start();
			tx({a, 1'b1}, x);
			ok = ok & x;
		end
		if (k >= 2) rx(q);
		stop();
	endtask
endmodule

// file: smbus_temp_regs.sv
// smbus slave and temperature result registers of a two-channel thermometer
//
// Functional notes
// - an aborted conversion leaves all temperature result registers unchanged
// - pin or software standby arriving mid-conversion interrupts that conversion
// - one single slave address serves every register and function
// - write byte, read byte, send byte and receive byte; eight-bit registers
// - receive byte returns the register chosen by the last command byte
// - command pointer resets to zero, so receive byte returns local temperature
// - local at 00h, remote at 01h, signed bytes with 1 degree LSB
// - data bytes leave most significant bit first
// - config bit 3 enables extended range down to -64 degrees on both channels
// - at 4 Hz or slower, index 10h holds three remote fraction bits
// - fraction is valid only at 4 Hz or slower, zero otherwise
// - remote main and fraction results update in the same cycle
// - config bit 6 enters standby, stopping automatic conversions, keeping data
// - send byte 0Fh starts a single conversion in run mode or software standby
// - status busy flag is 1 while converting and 0 after
`timescale 1ns/1ps
module smbus_temp_regs #(
	parameter logic [6:0] SLAVE_ADDR = 7'h4C,
	parameter longint PERIOD_CYCLES = temp_smbus_pkg::FAST_PERIOD_CYCLES,
	parameter longint CONV_CYCLES = temp_smbus_pkg::CONV_CYCLES
) (
	input wire logic sys_clk_i, // system clock, 250 MHz
	input wire logic reset_n_i, // async reset, active low
	input wire logic scl_i, // smbus clock pin level
	input wire logic sda_i, // smbus data pin level
	output logic sda_o, // smbus data drive value
	output logic sda_oe_o, // smbus data drive enable, high pulls low
	input wire logic standby_n_i, // standby pin, active low
	input wire logic signed [8:0] local_temp_i, // local measurement, whole degrees
	input wire logic signed [11:0] remote_temp_i, // remote measurement, 3 fraction bits
	output logic busy_o, // conversion in progress
	output logic standby_o // device in hardware or software standby
);
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_TX,
		ST_TX_ACK
	} bus_state_t;

	bus_state_t state_q;
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic [1:0] stby_sync_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [3:0] bit_cnt_q;
	logic rw_q;
	logic sda_oe_q;
	logic sda_o_q;
	logic [7:0] cmd_ptr_q;
	logic [7:0] config_q;
	logic [7:0] rate_q;
	logic [7:0] local_q;
	logic [7:0] remote_q;
	logic [7:0] fraction_q;
	logic one_shot_q;
	logic busy_q;
	logic standby_q;
	logic conv_busy;
	logic conv_done;

	// decode of pin events from the second and third synchroniser stages
	wire scl_s = scl_sync_q[1];
	wire sda_s = sda_sync_q[1];
	wire scl_rise = scl_s && !scl_sync_q[2];
	wire scl_fall = !scl_s && scl_sync_q[2];
	wire bus_start = scl_s && scl_sync_q[2] && !sda_s && sda_sync_q[2];
	wire bus_stop = scl_s && scl_sync_q[2] && sda_s && !sda_sync_q[2];
	wire byte_done = (bit_cnt_q == temp_smbus_pkg::BITS_PER_BYTE);
	wire addr_match = (shift_q[7:1] == SLAVE_ADDR);
	wire receiving = (state_q == ST_ADDR) || (state_q == ST_CMD) || (state_q == ST_WDATA);

	// mode decode
	wire hw_standby = !stby_sync_q[1];
	wire sw_standby = config_q[temp_smbus_pkg::CFG_STANDBY_BIT];
	wire ext_range = config_q[temp_smbus_pkg::CFG_EXT_RANGE_BIT];
	wire rate_fast_over = (rate_q > temp_smbus_pkg::RATE_FASTEST);
	wire [2:0] rate_sel = rate_fast_over ? temp_smbus_pkg::RATE_FASTEST[2:0] : rate_q[2:0];
	wire frac_ok = ({5'h00, rate_sel} <= temp_smbus_pkg::RATE_EXT_MAX);

	// clamp a whole-degree reading into the legacy or extended byte format
	function automatic logic [7:0] fmt_temp(input logic signed [8:0] t, input logic ext);
		logic signed [8:0] r;
		r = t;
		if (t > temp_smbus_pkg::TEMP_MAX) begin
			r = temp_smbus_pkg::TEMP_MAX;
		end else if (!ext && t < temp_smbus_pkg::TEMP_ZERO) begin
			r = temp_smbus_pkg::TEMP_ZERO;
		end else if (ext && t < temp_smbus_pkg::TEMP_EXT_MIN) begin
			r = temp_smbus_pkg::TEMP_EXT_MIN;
		end
		return r[7:0];
	endfunction

	wire [7:0] local_fmt = fmt_temp(local_temp_i, ext_range);
	wire [7:0] remote_fmt = fmt_temp(remote_temp_i[11:3], ext_range);
	wire [7:0] fraction_fmt = frac_ok ? {remote_temp_i[2:0], 5'h00} : 8'h00;

	// status byte: busy flag only
	wire [7:0] status_val = 8'(busy_q) << temp_smbus_pkg::STATUS_BUSY_BIT;

	// read mux keyed by the command pointer
	logic [7:0] rd_data;
	always_comb begin
		case (cmd_ptr_q)
			temp_smbus_pkg::IDX_LOCAL: rd_data = local_q;
			temp_smbus_pkg::IDX_REMOTE: rd_data = remote_q;
			temp_smbus_pkg::IDX_STATUS: rd_data = status_val;
			temp_smbus_pkg::IDX_CONFIG: rd_data = config_q;
			temp_smbus_pkg::IDX_RATE: rd_data = rate_q;
			temp_smbus_pkg::IDX_FRACTION: rd_data = fraction_q;
			default: rd_data = 8'h00;
		endcase
	end

	// write strobes from the write byte data phase, command and one-shot strobes from the command byte
	wire wr_byte = (state_q == ST_WDATA) && scl_fall && byte_done;
	wire wr_config = wr_byte && (cmd_ptr_q == temp_smbus_pkg::IDX_CONFIG);
	wire wr_rate = wr_byte && (cmd_ptr_q == temp_smbus_pkg::IDX_RATE);
	wire cmd_done = (state_q == ST_CMD) && scl_fall && byte_done;
	wire shot_cmd = cmd_done && (shift_q == temp_smbus_pkg::CMD_ONE_SHOT);

	// pin synchronisers; only the second stage onward feeds logic
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			stby_sync_q <= 2'h3;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl_i};
			sda_sync_q <= {sda_sync_q[1:0], sda_i};
			stby_sync_q <= {stby_sync_q[0], standby_n_i};
		end
	end

	// serial byte engine: address, command, write data and read data phases
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else if (bus_start) begin
			state_q <= ST_ADDR; // repeated start also lands here
			bit_cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			shift_q <= {shift_q[6:0], sda_s};
			if (receiving) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (byte_done && addr_match) begin
						rw_q <= shift_q[0];
						sda_oe_q <= 1'b1;
						state_q <= ST_ADDR_ACK;
					end else if (byte_done) begin
						state_q <= ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt_q <= rw_q ? 4'h1 : 4'h0;
					if (rw_q) begin
						tx_q <= rd_data;
						sda_oe_q <= !rd_data[7];
						state_q <= ST_TX;
					end else begin
						sda_oe_q <= 1'b0;
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (byte_done) begin
						sda_oe_q <= 1'b1;
						state_q <= ST_CMD_ACK;
					end
				end
				ST_CMD_ACK: begin
					sda_oe_q <= 1'b0;
					bit_cnt_q <= 4'h0;
					state_q <= ST_WDATA;
				end
				ST_WDATA: begin
					if (byte_done) begin
						sda_oe_q <= 1'b1;
						state_q <= ST_WDATA_ACK;
					end
				end
				ST_WDATA_ACK: begin
					sda_oe_q <= 1'b0;
					bit_cnt_q <= 4'h0;
					state_q <= ST_WDATA;
				end
				ST_TX: begin
					if (byte_done) begin
						sda_oe_q <= 1'b0;
						state_q <= ST_TX_ACK;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_q <= !tx_q[6];
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				ST_TX_ACK: begin
					if (!shift_q[0]) begin
						tx_q <= rd_data;
						sda_oe_q <= !rd_data[7];
						bit_cnt_q <= 4'h1;
						state_q <= ST_TX;
					end else begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// command pointer and writable registers
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_ptr_q <= temp_smbus_pkg::CMD_PTR_RESET;
			config_q <= temp_smbus_pkg::CONFIG_RESET;
			rate_q <= temp_smbus_pkg::RATE_RESET;
			one_shot_q <= 1'b0;
		end else begin
			one_shot_q <= shot_cmd;
			if (cmd_done) begin
				cmd_ptr_q <= shift_q;
			end
			if (wr_config) begin
				config_q <= shift_q;
			end
			if (wr_rate) begin
				rate_q <= shift_q;
			end
		end
	end

	// result registers load together only on a completed conversion
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			local_q <= temp_smbus_pkg::RESULT_RESET;
			remote_q <= temp_smbus_pkg::RESULT_RESET;
			fraction_q <= temp_smbus_pkg::RESULT_RESET;
		end else if (conv_done) begin
			local_q <= local_fmt;
			remote_q <= remote_fmt;
			fraction_q <= fraction_fmt;
		end
	end

	// registered status outputs
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_q <= 1'b0;
			standby_q <= 1'b0;
		end else begin
			busy_q <= conv_busy;
			standby_q <= hw_standby || sw_standby;
		end
	end

	conv_sequencer #(
		.PERIOD_CYCLES(PERIOD_CYCLES),
		.CONV_CYCLES(CONV_CYCLES)
	) u_seq (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.rate_sel_i(rate_sel),
		.hw_standby_i(hw_standby),
		.sw_standby_i(sw_standby),
		.one_shot_i(one_shot_q),
		.busy_o(conv_busy),
		.done_o(conv_done)
	);

	assign sda_o = sda_o_q;
	assign sda_oe_o = sda_oe_q;
	assign busy_o = busy_q;
	assign standby_o = standby_q;
endmodule

// file: smbus_temp_regs_asserts.sv
// concurrent checks on the ports of the smbus temperature block
`timescale 1ns/1ps
module smbus_temp_regs_asserts #(
	parameter longint PERIOD_CYCLES = 200,
	parameter longint CONV_CYCLES = 50
) (
	input wire logic sys_clk_i, // system clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic scl_i, // clock pin
	input wire logic sda_i, // data pin
	input wire logic sda_o, // data drive value
	input wire logic sda_oe_o, // data drive enable
	input wire logic standby_n_i, // standby pin
	input wire logic signed [8:0] local_temp_i, // local measurement
	input wire logic signed [11:0] remote_temp_i, // remote measurement
	input wire logic busy_o, // conversion running
	input wire logic standby_o // standby active
);
	logic [15:0] busy_cnt_q;
	// counts how long busy has stood
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_cnt_q <= 16'h0000;
		end else begin
			busy_cnt_q <= busy_o ? busy_cnt_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// pin and conversion relations
	sda_zero_a: assert property (sda_o == 1'b0) else $error("drive value not low");
	bit_stands_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
		else $error("driven bit too short");
	oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data drive moved while clock high");
	idle_release_a: assert property (scl_i [*8] |-> !sda_oe_o)
		else $error("data driven on idle bus");
	pin_flag_a: assert property ((!standby_n_i) [*5] |-> standby_o)
		else $error("standby flag missing");
	pin_abort_a: assert property ((!standby_n_i) [*6] |-> !busy_o)
		else $error("conversion runs in pin standby");
	busy_max_a: assert property (busy_o |-> busy_cnt_q <= CONV_CYCLES + 1)
		else $error("busy stands too long");
	conv_len_a: assert property ($fell(busy_o) && !standby_o && $past(standby_n_i, 8)
		|-> busy_cnt_q >= CONV_CYCLES - 1 && busy_cnt_q <= CONV_CYCLES + 1)
		else $error("conversion length wrong");
	cover property ($fell(busy_o));
	cover property ($rose(sda_oe_o));
	cover property ((!standby_n_i) [*6]);
endmodule

bind smbus_temp_regs smbus_temp_regs_asserts #(.PERIOD_CYCLES(PERIOD_CYCLES),
	.CONV_CYCLES(CONV_CYCLES)) chk_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.standby_n_i(standby_n_i), .local_temp_i(local_temp_i), .remote_temp_i(remote_temp_i),
	.busy_o(busy_o), .standby_o(standby_o));

// file: smbus_temperature_register_access_bench.sv
// self-checking bench for the smbus temperature register block
`timescale 1ns/1ps
module smbus_temperature_register_access_bench;
	localparam logic [6:0] A = 7'h4C;
	logic sys_clk, reset_n, scl, oe, drv, hl, busy, stby, stby_n, ok;
	logic signed [8:0] lt;
	logic signed [11:0] rt;
	logic [7:0] q, el, er, ef;
	logic [31:0] r;
	logic signed [8:0] cl [4] = '{9'h0C8, 9'h1C0, 9'h1BF, 9'h1FF};
	int bad_count = 0;
	int comparisons = 0;
	int seed = 32'h9feb8877;
	wire sda = !(oe | hl); // pulled up, low when either side pulls
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	smbus_temp_regs #(.PERIOD_CYCLES(200), .CONV_CYCLES(150)) dut (.sys_clk_i(sys_clk),
		.reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(drv), .sda_oe_o(oe),
		.standby_n_i(stby_n), .local_temp_i(lt), .remote_temp_i(rt), .busy_o(busy),
		.standby_o(stby));
	smbus_host_model host (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(hl));
	// expected byte for a whole-degree value
	function automatic logic [7:0] ex_t(input logic signed [8:0] v, input logic e);
		if (v > temp_smbus_pkg::TEMP_MAX) return 8'h7F;
		if (v < temp_smbus_pkg::TEMP_ZERO && !e) return 8'h00;
		if (v < temp_smbus_pkg::TEMP_EXT_MIN) return 8'hC0;
		return v[7:0];
	endfunction
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// bounded wait for busy to reach a level
	task automatic wb(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 1200) begin
			@(posedge sys_clk);
			n++;
		end
		chk("busy wait", {7'h00, busy}, {7'h00, v});
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		host.xfer(A, 0, c, d, q, ok);
		chk("write ack", {7'h00, ok}, 8'h01);
	endtask
	task automatic rd(input logic [7:0] c);
		host.xfer(A, 2, c, 8'h00, q, ok);
		chk("read ack", {7'h00, ok}, 8'h01);
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		stby_n = 1'b1;
		lt = 9'h019;
		rt = 12'h000;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wb(1'b1);
		wb(1'b0);
		host.xfer(A, 3, 8'h00, 8'h00, q, ok);
		chk("receive after reset", q, 8'h19);
		host.xfer(A ^ 7'h01, 1, temp_smbus_pkg::CMD_ONE_SHOT, 8'h00, q, ok);
		chk("foreign address ack", {7'h00, ok}, 8'h00);
		wr(temp_smbus_pkg::IDX_RATE, 8'h06);
		// standby one-shots over corner and random temperatures
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			lt <= (i < 4) ? cl[i] : r[8:0];
			rt <= (i < 4) ? {cl[3 - i], r[2:0]} : (r[20:9] | 12'h001);
			// code above 7 must act as 8 Hz, so no fraction although its low bits say 6
			if (i == 5) wr(temp_smbus_pkg::IDX_RATE, 8'h0E);
			wr(temp_smbus_pkg::IDX_CONFIG, {4'h4, i[0], 3'h0});
			rd(temp_smbus_pkg::IDX_CONFIG);
			chk("config", q, {4'h4, i[0], 3'h0});
			host.xfer(A, 1, temp_smbus_pkg::CMD_ONE_SHOT, 8'h00, q, ok);
			wb(1'b1);
			wb(1'b0);
			el = ex_t(lt, i[0]);
			er = ex_t(rt[11:3], i[0]);
			ef = (i == 5) ? 8'h00 : {rt[2:0], 5'h00};
			rd(temp_smbus_pkg::IDX_LOCAL);
			chk("local", q, el);
			rd(temp_smbus_pkg::IDX_REMOTE);
			chk("remote", q, er);
			rd(temp_smbus_pkg::IDX_FRACTION);
			chk("fraction", q, ef);
		end
		// software standby keeps results and stops conversions
		lt <= 9'h033;
		repeat (600) @(posedge sys_clk);
		chk("standby busy", {7'h00, busy}, 8'h00);
		rd(temp_smbus_pkg::IDX_LOCAL);
		chk("retained", q, el);
		// run mode, then pin standby aborts a running conversion
		wr(temp_smbus_pkg::IDX_CONFIG, 8'h00);
		// point at status, then catch a fresh conversion and read busy through receive byte
		host.xfer(A, 1, temp_smbus_pkg::IDX_STATUS, 8'h00, q, ok);
		wb(1'b0);
		wb(1'b1);
		host.xfer(A, 3, 8'h00, 8'h00, q, ok);
		chk("status busy", q, 8'h80);
		wb(1'b0);
		wb(1'b1);
		lt <= 9'h044;
		repeat (10) @(posedge sys_clk);
		stby_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk("abort busy", {6'h00, stby, busy}, 8'h02);
		host.xfer(A, 1, temp_smbus_pkg::CMD_ONE_SHOT, 8'h00, q, ok);
		repeat (20) @(posedge sys_clk);
		chk("pin one-shot", {7'h00, busy}, 8'h00);
		host.xfer(A, 3, 8'h00, 8'h00, q, ok);
		chk("unlisted index", q, 8'h00);
		wr(temp_smbus_pkg::IDX_CONFIG, 8'h40);
		stby_n <= 1'b1;
		rd(temp_smbus_pkg::IDX_LOCAL);
		chk("abort keeps", q, 8'h33);
		rd(temp_smbus_pkg::IDX_STATUS);
		chk("status idle", q, 8'h00);
		chk("drive value", {7'h00, drv}, 8'h00);
		final_report();
	end
endmodule

// file: temp_smbus_pkg.sv
// constants shared by the smbus temperature register block and its conversion sequencer
package temp_smbus_pkg;

	// bus geometry
	localparam int ADDR_W = 7;
	localparam int REG_W = 8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// register indices seen through the command pointer
	localparam logic [7:0] IDX_LOCAL = 8'h00;
	localparam logic [7:0] IDX_REMOTE = 8'h01;
	localparam logic [7:0] IDX_STATUS = 8'h02;
	localparam logic [7:0] IDX_CONFIG = 8'h03;
	localparam logic [7:0] IDX_RATE = 8'h04;
	localparam logic [7:0] IDX_FRACTION = 8'h10;
	localparam logic [7:0] CMD_ONE_SHOT = 8'h0F;

	// field positions
	localparam int CFG_STANDBY_BIT = 6;
	localparam int CFG_EXT_RANGE_BIT = 3;
	localparam int STATUS_BUSY_BIT = 7;

	// reset values
	localparam logic [7:0] CMD_PTR_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h05;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// conversion rate codes: each step down halves the rate, the top code is 8 Hz
	localparam logic [7:0] RATE_FASTEST = 8'h07;
	localparam logic [7:0] RATE_EXT_MAX = 8'h06;

	// temperature clamps, two's complement whole degrees
	localparam logic signed [8:0] TEMP_MAX = 9'h07F;
	localparam logic signed [8:0] TEMP_ZERO = 9'h000;
	localparam logic signed [8:0] TEMP_EXT_MIN = 9'h1C0;

	// timing
	localparam longint CLK_HZ = 250_000_000;
	localparam longint FAST_RATE_HZ = 8;
	localparam longint FAST_PERIOD_CYCLES = CLK_HZ / FAST_RATE_HZ;
	localparam longint CONV_TIME_US = 62_500;
	localparam longint CONV_CYCLES = (CONV_TIME_US * CLK_HZ) / 1_000_000;

endpackage
